// ### src/ois_regs.vh
// Register offsets, field positions and timing counts of the core interrupt status block
`ifndef OIS_REGS_VH
`define OIS_REGS_VH
`define OIS_STATUS_OFFSET 8'h14
`define OIS_STATUS_RESET 32'h0000_0000
`define OIS_BIT_WAKEUP 31
`define OIS_BIT_SESSION 30
`define OIS_BIT_DISCONNECT 29
`define OIS_BIT_CONN_ID 28
`define OIS_BIT_LINK_PWR 27
`define OIS_BIT_PER_TX_EMPTY 26
`define OIS_BIT_HOST_CHAN 25
`define OIS_BIT_HOST_PORT 24
`define OIS_BIT_SUSP_RESET 23
`define OIS_BIT_FETCH_SUSP 22
`define OIS_BIT_INCOMPL_PER 21
`define OIS_BIT_INCOMPL_ISO_IN 20
`define OIS_BIT_OUT_EP 19
`define OIS_BIT_IN_EP 18
`define OIS_BIT_EP_MISMATCH 17
`define OIS_BIT_RESTORE_DONE 16
`define OIS_BIT_PER_FRAME_END 15
`define OIS_BIT_ISO_DROP 14
`define OIS_BIT_ENUM_DONE 13
`define OIS_BIT_BUS_RESET 12
`define OIS_BIT_BUS_SUSPEND 11
`define OIS_BIT_EARLY_IDLE 10
`define OIS_BIT_OUT_NAK 7
`define OIS_BIT_IN_NAK 6
`define OIS_BIT_NP_TX_EMPTY 5
`define OIS_BIT_RX_PENDING 4
`define OIS_BIT_FRAME_START 3
`define OIS_BIT_OTG_EVENT 2
`define OIS_BIT_ROLE_MISMATCH 1
`define OIS_BIT_ROLE 0
// Write-one-to-clear bit set: 31..27, 23..20, 17..10, 3, 1
`define OIS_W1C_MASK 32'hf8f3_fc0a
// Early idle time and its cycle count at 250 MHz
`define OIS_EARLY_IDLE_US 3000
`define OIS_CLK_MHZ 250
`define OIS_EARLY_IDLE_CYCLES (`OIS_EARLY_IDLE_US * `OIS_CLK_MHZ)
// Suspend idle period counted from idle start, parameter default
`define OIS_SUSPEND_CYCLES (10000 * `OIS_CLK_MHZ)
// Soft reset self-clear sequence length in cycles
`define OIS_SOFT_RESET_CYCLES 4'h8
`endif

// ### src/ois_sync.v
// Two-flop synchroniser for one asynchronous level
`default_nettype none
module ois_sync
(
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Data
  input wire async_in,
  output reg sync_out
);
  reg stage1;

  // First stage feeds only the second stage
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (clk_en)
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // ois_sync
`default_nettype wire

// ### src/ois_core.v
// Core interrupt status register with role tracking, idle timers and soft reset control
//
// Contract
// [RULE_01] Soft reset request bit self-clears after internal reset sequence finishes.
// [RULE_02] Software waits three PHY clocks after self-clear before PHY domain access.
// [RULE_03] Software checks master idle flag reads one before starting operation.
// [RULE_04] Software issues soft reset after changing PHY selection.
// [RULE_05] Wakeup flag: L2 role-specific resume source, L1 either source.
// [RULE_06] Session flag: host on session request, device on session-valid rise.
// [RULE_07] Disconnect flag on disconnect; identity change flag on ID change.
// [RULE_08] LPM flag only when enabled; role-specific completion events.
// [RULE_09] Periodic TX empty flag follows level setting and queue room.
// [RULE_10] Host channel, port and OTG summaries are read-only ORs.
// [RULE_11] Suspended reset flag only in device role during partial power-down.
// [RULE_12] Fetch suspended flag only in DMA mode on lack of space.
// [RULE_13] Incomplete flags set with frame end; ISO IN never in scatter/gather.
// [RULE_14] OUT and IN endpoint summaries are read-only ORs.
// [RULE_15] Endpoint mismatch only in shared FIFO with all conditions coinciding.
// [RULE_16] Periodic frame end flag when interval point reached.
// [RULE_17] ISO OUT drop flag when receive FIFO lacks room.
// [RULE_18] Enumeration complete and bus reset flags on their events.
// [RULE_19] Early idle after 3 ms idle; suspend after longer idle.
// [RULE_20] NAK effective flags follow set and clear controls.
// [RULE_21] Non-periodic empty only in shared FIFO; receive pending follows FIFO.
// [RULE_22] Frame start flag on role-specific frame start event.
// [RULE_23] Mismatch flag on wrong-role access; access completes but is ignored.
// [RULE_24] Bit 0 shows role: zero device, one host.
// [RULE_25] Write one clears flag; zero keeps it; new event beats clear.
`include "ois_regs.vh"
`default_nettype none
module ois_core
#(
  parameter EARLY_IDLE_CYCLES = `OIS_EARLY_IDLE_CYCLES,
  parameter SUSPEND_CYCLES = `OIS_SUSPEND_CYCLES
)
(
  // Clock, reset, enable
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Register port
  input wire reg_sel,
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  input wire access_host_reg,
  input wire access_dev_reg,
  // Soft reset control and wrong-role access flag
  input wire soft_reset_write,
  output reg core_soft_reset_request,
  output reg master_idle_flag,
  output reg core_reset_active,
  output reg access_ignored,
  // Configuration
  input wire host_role,
  input wire lpm_enable,
  input wire dma_mode,
  input wire scatter_gather_mode,
  input wire dedicated_tx_fifo_option,
  input wire periodic_tx_empty_level,
  input wire nonperiodic_tx_empty_level,
  input wire partial_power_down,
  input wire l1_sleep,
  input wire l2_suspend,
  // Core events (one-cycle pulses, same clock; pending inputs and master_busy are levels)
  input wire host_resume_seen,
  input wire remote_wakeup_seen,
  input wire session_request_seen,
  input wire disconnect_seen,
  input wire lpm_ok_response,
  input wire lpm_retry_exhausted,
  input wire bus_reset_seen,
  input wire fetch_stalled,
  input wire periodic_interval_hit,
  input wire iso_out_pending,
  input wire iso_in_pending,
  input wire np_in_token,
  input wire np_fifo_head_other_ep,
  input wire mismatch_count_expired,
  input wire restore_done,
  input wire iso_out_no_room,
  input wire enum_done,
  input wire frame_start_seen,
  input wire set_out_nak_control,
  input wire clear_out_nak_control,
  input wire set_in_nak_control,
  input wire clear_in_nak_control,
  input wire master_busy,
  // Levels from FIFOs and sub-registers (same clock)
  input wire periodic_tx_half_empty,
  input wire periodic_tx_all_empty,
  input wire periodic_queue_room,
  input wire np_tx_half_empty,
  input wire np_tx_all_empty,
  input wire np_queue_room,
  input wire rx_packet_pending,
  input wire [15:0] all_channels_status,
  input wire host_port_control_status,
  input wire [31:0] all_endpoints_status,
  input wire [15:0] otg_event_status,
  // Asynchronous pins
  input wire session_valid_pin,
  input wire connector_id_pin,
  input wire line_active_pin,
  // Summary
  output reg [31:0] core_interrupt_status
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RESET = 2'd1;
  localparam ST_DONE = 2'd2;

  wire session_valid;
  wire connector_id;
  wire line_active;
  reg session_valid_q;
  reg connector_id_q;
  reg [1:0] rst_state;
  reg [3:0] rst_count;
  reg [31:0] idle_count;
  reg [31:0] set_vec;
  reg [31:0] clr_vec;
  reg [31:0] live;
  reg out_nak;
  reg in_nak;
  wire status_wr;
  wire mismatch;

  ois_sync u_sync_sv (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .async_in(session_valid_pin), .sync_out(session_valid));
  ois_sync u_sync_id (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .async_in(connector_id_pin), .sync_out(connector_id));
  ois_sync u_sync_ls (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .async_in(line_active_pin), .sync_out(line_active));

  assign status_wr = reg_sel && reg_write && (reg_addr == `OIS_STATUS_OFFSET);
  assign mismatch = reg_sel && ((access_host_reg && !host_role) || (access_dev_reg && host_role)); // [RULE_23]

  // Event set vector; sources qualified here by role and mode where their rule requires it
  always @*
  begin
    set_vec = 32'h0000_0000;
    set_vec[`OIS_BIT_WAKEUP] = l1_sleep ? (host_resume_seen | remote_wakeup_seen) :
      (l2_suspend && (host_role ? remote_wakeup_seen : host_resume_seen)); // [RULE_05]
    set_vec[`OIS_BIT_SESSION] = host_role ? session_request_seen : (session_valid & ~session_valid_q); // [RULE_06]
    set_vec[`OIS_BIT_DISCONNECT] = disconnect_seen; // [RULE_07]
    set_vec[`OIS_BIT_CONN_ID] = connector_id ^ connector_id_q; // [RULE_07]
    set_vec[`OIS_BIT_LINK_PWR] = lpm_enable && (lpm_ok_response || (host_role && lpm_retry_exhausted)); // [RULE_08]
    set_vec[`OIS_BIT_SUSP_RESET] = !host_role && partial_power_down && l2_suspend && bus_reset_seen; // [RULE_11]
    set_vec[`OIS_BIT_FETCH_SUSP] = dma_mode && fetch_stalled; // [RULE_12]
    set_vec[`OIS_BIT_INCOMPL_PER] = periodic_interval_hit && iso_out_pending; // [RULE_13]
    set_vec[`OIS_BIT_INCOMPL_ISO_IN] = periodic_interval_hit && iso_in_pending && !scatter_gather_mode; // [RULE_13]
    set_vec[`OIS_BIT_EP_MISMATCH] = !dedicated_tx_fifo_option && np_in_token &&
      np_fifo_head_other_ep && mismatch_count_expired; // [RULE_15]
    set_vec[`OIS_BIT_RESTORE_DONE] = restore_done;
    set_vec[`OIS_BIT_PER_FRAME_END] = periodic_interval_hit; // [RULE_16]
    set_vec[`OIS_BIT_ISO_DROP] = iso_out_no_room; // [RULE_17]
    set_vec[`OIS_BIT_ENUM_DONE] = enum_done; // [RULE_18]
    set_vec[`OIS_BIT_BUS_RESET] = bus_reset_seen; // [RULE_18]
    set_vec[`OIS_BIT_EARLY_IDLE] = (idle_count == EARLY_IDLE_CYCLES); // [RULE_19]
    set_vec[`OIS_BIT_BUS_SUSPEND] = (idle_count == SUSPEND_CYCLES); // [RULE_19]
    set_vec[`OIS_BIT_FRAME_START] = frame_start_seen; // [RULE_22]
    set_vec[`OIS_BIT_ROLE_MISMATCH] = mismatch; // [RULE_23]
  end

  // Write-one clear vector, limited to sticky bits
  always @*
  begin
    clr_vec = 32'h0000_0000;
    if (status_wr && !mismatch)
      clr_vec = reg_wdata & `OIS_W1C_MASK; // [RULE_25]
  end

  // Read-only live bits, recomputed each cycle from sources
  always @*
  begin
    live = 32'h0000_0000;
    live[`OIS_BIT_PER_TX_EMPTY] = (periodic_tx_empty_level ? periodic_tx_all_empty : periodic_tx_half_empty)
      && periodic_queue_room; // [RULE_09]
    live[`OIS_BIT_HOST_CHAN] = |all_channels_status; // [RULE_10]
    live[`OIS_BIT_HOST_PORT] = host_port_control_status; // [RULE_10]
    live[`OIS_BIT_OTG_EVENT] = |otg_event_status; // [RULE_10]
    live[`OIS_BIT_OUT_EP] = |all_endpoints_status[31:16]; // [RULE_14]
    live[`OIS_BIT_IN_EP] = |all_endpoints_status[15:0]; // [RULE_14]
    live[`OIS_BIT_OUT_NAK] = out_nak; // [RULE_20]
    live[`OIS_BIT_IN_NAK] = in_nak; // [RULE_20]
    live[`OIS_BIT_NP_TX_EMPTY] = !dedicated_tx_fifo_option && np_queue_room &&
      (nonperiodic_tx_empty_level ? np_tx_all_empty : np_tx_half_empty); // [RULE_21]
    live[`OIS_BIT_RX_PENDING] = rx_packet_pending; // [RULE_21]
    live[`OIS_BIT_ROLE] = host_role; // [RULE_24]
  end

  // Pin history for edge detection on synchronised levels
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      session_valid_q <= 1'b0;
      connector_id_q <= 1'b0;
    end
    else if (clk_en)
    begin
      session_valid_q <= session_valid;
      connector_id_q <= connector_id;
    end
  end

  // Bus idle counter; saturates past suspend so each flag fires once per idle stretch
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      idle_count <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (line_active || core_reset_active)
        idle_count <= 32'h0000_0000;
      else if (idle_count <= SUSPEND_CYCLES)
        idle_count <= idle_count + 32'h0000_0001; // [RULE_19]
    end
  end

  // NAK effective states; set control wins a same-cycle clear
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_nak <= 1'b0;
      in_nak <= 1'b0;
    end
    else if (clk_en)
    begin
      if (core_reset_active)
      begin
        out_nak <= 1'b0;
        in_nak <= 1'b0;
      end
      else
      begin
        if (set_out_nak_control)
          out_nak <= 1'b1; // [RULE_20]
        else if (clear_out_nak_control)
          out_nak <= 1'b0; // [RULE_20]
        if (set_in_nak_control)
          in_nak <= 1'b1; // [RULE_20]
        else if (clear_in_nak_control)
          in_nak <= 1'b0; // [RULE_20]
      end
    end
  end

  // Status register: sticky bits with set over clear, live bits copied
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      core_interrupt_status <= `OIS_STATUS_RESET;
    else if (clk_en)
    begin
      if (core_reset_active)
        core_interrupt_status <= `OIS_STATUS_RESET | live;
      else
        core_interrupt_status <= (((core_interrupt_status & ~clr_vec) | set_vec) & `OIS_W1C_MASK) | live; // [RULE_25]
    end
  end

  // Soft reset sequencer; request self-clears after fixed reset sweep once master is idle
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_state <= ST_IDLE;
      rst_count <= 4'h0;
      core_soft_reset_request <= 1'b0;
      core_reset_active <= 1'b0;
    end
    else if (clk_en)
    begin
      case (rst_state)
        ST_IDLE:
        begin
          if (soft_reset_write)
          begin
            rst_state <= ST_RESET;
            rst_count <= 4'h0;
            core_soft_reset_request <= 1'b1;
            core_reset_active <= 1'b1;
          end
        end
        ST_RESET:
        begin
          // Waits for master to finish its last data phase before releasing
          if (rst_count != `OIS_SOFT_RESET_CYCLES)
            rst_count <= rst_count + 4'h1;
          else if (!master_busy)
          begin
            rst_state <= ST_DONE;
            core_reset_active <= 1'b0;
          end
        end
        ST_DONE:
        begin
          core_soft_reset_request <= 1'b0; // [RULE_01]
          rst_state <= ST_IDLE;
        end
        default:
          rst_state <= ST_IDLE;
      endcase
    end
  end

  // Master idle view for software polling after reset
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      master_idle_flag <= 1'b1;
    else if (clk_en)
      master_idle_flag <= !master_busy && !core_reset_active; // [RULE_03]
  end

  // Register read port and wrong-role access suppression
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
      access_ignored <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_ack <= reg_sel; // Always OKAY, mismatched or not
      access_ignored <= mismatch; // [RULE_23]
      if (reg_sel && !reg_write && (reg_addr == `OIS_STATUS_OFFSET) && !mismatch)
        reg_rdata <= core_interrupt_status;
      else
        reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // ois_core
`default_nettype wire

// ### verif/ois_core_chk.sv
// Assertion checker for the core interrupt status block
`default_nettype none
module ois_chk (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Register port
  input wire reg_sel,
  input wire reg_ack,
  input wire [31:0] reg_rdata,
  input wire access_host_reg,
  input wire access_dev_reg,
  input wire access_ignored,
  // Soft reset
  input wire soft_reset_write,
  input wire core_soft_reset_request,
  input wire core_reset_active,
  // Sources and status
  input wire host_role,
  input wire bus_reset_seen,
  input wire [15:0] all_channels_status,
  input wire [31:0] all_endpoints_status,
  input wire [31:0] core_interrupt_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Event flags are held at their reset value during soft reset, so those cycles are left out
  wire run = clk_en && !core_reset_active;
  wire bad = run && reg_sel && (host_role ? access_dev_reg : access_host_reg);
  AST_ACK: assert property (clk_en && reg_sel |=> reg_ack)
    else $error("register access not acknowledged");
  AST_ROLE: assert property (clk_en |=> core_interrupt_status[0] == $past(host_role))
    else $error("role bit wrong");
  AST_CHAN: assert property (clk_en |=> core_interrupt_status[25] == |$past(all_channels_status))
    else $error("channel summary wrong");
  AST_EP: assert property (clk_en |=> core_interrupt_status[19:18] ==
    {|$past(all_endpoints_status[31:16]), |$past(all_endpoints_status[15:0])})
    else $error("endpoint summary wrong");
  AST_BUS_RESET: assert property (run && bus_reset_seen |=> core_interrupt_status[12])
    else $error("bus reset flag not set");
  AST_HOST_NO_SUSP_RESET: assert property (clk_en && host_role |=> !$rose(core_interrupt_status[23]))
    else $error("suspended reset flag set in host role");
  AST_MISMATCH: assert property (bad |=> core_interrupt_status[1] && access_ignored && reg_rdata == 32'h0)
    else $error("role mismatch not handled");
  AST_SOFT_RESET: assert property (clk_en && soft_reset_write && !core_soft_reset_request |=>
    core_soft_reset_request ##[5:60] !core_soft_reset_request)
    else $error("soft reset request did not self clear");
  COV_MISMATCH: cover property (bad);
  COV_SOFT: cover property ($fell(core_soft_reset_request));
  COV_BUS_RESET: cover property (run && bus_reset_seen);
endmodule // ois_chk

bind ois_core ois_chk u_chk (.ref_clk, .nrst, .clk_en, .reg_sel, .reg_ack, .reg_rdata, .access_host_reg,
  .access_dev_reg, .access_ignored, .soft_reset_write, .core_soft_reset_request, .core_reset_active,
  .host_role, .bus_reset_seen, .all_channels_status, .all_endpoints_status, .core_interrupt_status);
`default_nettype wire

// ### verif/ois_core_bench.sv
// Self-checking bench for the core interrupt status block
`default_nettype none
module ois_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0, sel = 1'b0, wr = 1'b0, ah = 1'b0, ad = 1'b0, srw = 1'b0, port = 1'b0, en = 1'b1;
  logic [7:0] addr = 8'h14;
  logic [31:0] wd = 32'h0, eps = 32'h0, rdat, st;
  logic [19:0] ev = 20'h0;
  logic [9:0] cfg = 10'h0;
  logic [6:0] lv = 7'h0;
  logic [2:0] misc = 3'h0, pins = 3'h4;
  logic [15:0] chan = 16'h0, otg = 16'h0;
  logic ack, req, idle, act, ign;
  logic [31:0] expq[$];
  int mismatches = 0, total_checks = 0, cyc = 0, i;
  // Event mask, expected flags, follow-up clearing event
  logic [71:0] tab [17] = '{
    {20'h00001, 32'h0000_1000, 20'h0},
    {20'h00002, 32'h0000_2000, 20'h0},
    {20'h00004, 32'h0000_4000, 20'h0},
    {20'h00008, 32'h0000_8000, 20'h0},
    {20'h00010, 32'h2000_0000, 20'h0},
    {20'h00020, 32'h0000_0008, 20'h0},
    {20'h00040, 32'h0001_0000, 20'h0},
    {20'h00080, 32'h0800_0000, 20'h0},
    {20'h01000, 32'h0800_0000, 20'h0},
    {20'h00100, 32'h4000_0000, 20'h0},
    {20'h00200, 32'h0040_0000, 20'h0},
    {20'h00400, 32'h0000_0000, 20'h0},
    {20'h00800, 32'h8000_0000, 20'h0},
    {20'h0e000, 32'h0002_0000, 20'h0},
    {20'h06000, 32'h0000_0000, 20'h0},
    {20'h10000, 32'h0000_0080, 20'h20000},
    {20'h40000, 32'h0000_0040, 20'h80000}};

  ois_core #(.EARLY_IDLE_CYCLES(20), .SUSPEND_CYCLES(40)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(en), .reg_sel(sel), .reg_write(wr), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack), .access_host_reg(ah), .access_dev_reg(ad),
    .soft_reset_write(srw), .core_soft_reset_request(req), .master_idle_flag(idle),
    .core_reset_active(act), .access_ignored(ign), .host_role(cfg[0]), .lpm_enable(cfg[1]),
    .dma_mode(cfg[2]), .scatter_gather_mode(cfg[3]), .dedicated_tx_fifo_option(cfg[4]),
    .periodic_tx_empty_level(cfg[5]), .nonperiodic_tx_empty_level(cfg[6]), .partial_power_down(cfg[7]),
    .l1_sleep(cfg[8]), .l2_suspend(cfg[9]), .host_resume_seen(ev[10]), .remote_wakeup_seen(ev[11]),
    .session_request_seen(ev[8]), .disconnect_seen(ev[4]), .lpm_ok_response(ev[7]),
    .lpm_retry_exhausted(ev[12]), .bus_reset_seen(ev[0]), .fetch_stalled(ev[9]),
    .periodic_interval_hit(ev[3]), .iso_out_pending(misc[0]), .iso_in_pending(misc[1]),
    .np_in_token(ev[13]), .np_fifo_head_other_ep(ev[14]), .mismatch_count_expired(ev[15]),
    .restore_done(ev[6]), .iso_out_no_room(ev[2]), .enum_done(ev[1]), .frame_start_seen(ev[5]),
    .set_out_nak_control(ev[16]), .clear_out_nak_control(ev[17]), .set_in_nak_control(ev[18]),
    .clear_in_nak_control(ev[19]), .master_busy(misc[2]), .periodic_tx_half_empty(lv[0]),
    .periodic_tx_all_empty(lv[1]), .periodic_queue_room(lv[2]), .np_tx_half_empty(lv[3]),
    .np_tx_all_empty(lv[4]), .np_queue_room(lv[5]), .rx_packet_pending(lv[6]),
    .all_channels_status(chan), .host_port_control_status(port), .all_endpoints_status(eps),
    .otg_event_status(otg), .session_valid_pin(pins[0]), .connector_id_pin(pins[1]),
    .line_active_pin(pins[2]), .core_interrupt_status(st));

  // 250 MHz clock
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  // Summary and level bits that follow the current inputs
  function automatic logic [31:0] live();
    logic [31:0] v;
    v = 32'h0;
    v[26] = lv[2] & (cfg[5] ? lv[1] : lv[0]);
    v[25] = |chan;
    v[24] = port;
    v[19] = |eps[31:16];
    v[18] = |eps[15:0];
    v[5] = ~cfg[4] & lv[5] & (cfg[6] ? lv[4] : lv[3]);
    v[4] = lv[6];
    v[2] = |otg;
    v[0] = cfg[0];
    return v;
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One register cycle; the answer is noted before the request goes out
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge ref_clk);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wd <= d;
    expq.push_back(e);
    @(posedge ref_clk);
    sel <= 1'b0;
    ah <= 1'b0;
    ad <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] e);
    acc(1'b0, 8'h14, 32'h0, e);
  endtask

  task automatic wrs(input logic [31:0] d);
    acc(1'b1, 8'h14, d, 32'h0);
  endtask

  task automatic pulse(input logic [19:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 20'h0;
  endtask

  // Fresh random levels, one event, read, clear by write, read again
  task automatic evt(input logic [19:0] m, input logic [31:0] e, input logic [19:0] c);
    // One edge first, so a caller's own setup never shares a time step with these
    tick(1);
    chan <= 16'($urandom);
    eps <= $urandom;
    otg <= 16'($urandom);
    port <= 1'($urandom);
    lv <= 7'($urandom);
    cfg[6:5] <= 2'($urandom);
    tick(3);
    pulse(m);
    tick(2);
    rd(e | live());
    wrs(e);
    pulse(c);
    tick(2);
    rd(live());
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Answers are compared with the oldest note; hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (ack === 1'b1)
      cmp(rdat, expq.pop_front());
    if (cyc == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'h8fcb));
    tick(8);
    nrst <= 1'b1;
    tick(2);
    cmp({31'h0, idle}, 32'h1);
    rd(32'h0);
    acc(1'b0, 8'h18, 32'h0, 32'h0);
    cfg <= 10'h287;
    for (i = 0; i < 17; i++)
      evt(tab[i][71:52], tab[i][51:20], tab[i][19:0]);
    // Unfinished periodic work at frame end, with and without scatter/gather
    for (i = 0; i < 2; i++)
    begin
      cfg[3] <= i[0];
      misc <= 3'h3;
      evt(20'h8, i ? 32'h0020_8000 : 32'h0030_8000, 20'h0);
    end
    misc <= 3'h0;
    // A new event in the clearing cycle wins, a zero write keeps the flag
    fork
      wrs(32'h1000);
      begin
        tick(1);
        ev <= 20'h1;
        tick(1);
        ev <= 20'h0;
      end
    join
    tick(2);
    wrs(32'h0);
    tick(1);
    rd(32'h1000 | live());
    wrs(32'h1000);
    tick(1);
    ad <= 1'b1;
    rd(32'h0);
    tick(1);
    rd(32'h2 | live());
    wrs(32'h2);
    // Soft reset as after a PHY selection change, flag pending and master busy
    pulse(20'h1);
    tick(1);
    srw <= 1'b1;
    misc <= 3'h4;
    tick(1);
    srw <= 1'b0;
    tick(2);
    cmp({30'h0, act, idle}, 32'h2);
    tick(12);
    cmp({31'h0, req}, 32'h1);
    misc <= 3'h0;
    for (i = 0; i < 60 && req !== 1'b0; i++)
      tick(1);
    cmp({31'h0, req}, 32'h0);
    tick(3);
    cmp({31'h0, idle}, 32'h1);
    rd(live());
    // Line idle: early idle first, suspend later
    pins[2] <= 1'b0;
    tick(30);
    rd(32'h400 | live());
    tick(50);
    rd(32'hc00 | live());
    pins[2] <= 1'b1;
    wrs(32'hc00);
    tick(2);
    rd(live());
    // Device role in L2 with partial power-down, then L1
    cfg <= 10'h280;
    evt(20'h1, 32'h0080_1000, 20'h0);
    evt(20'h400, 32'h8000_0000, 20'h0);
    evt(20'h80, 32'h0, 20'h0);
    pins[1:0] <= 2'h3;
    tick(8);
    rd(32'h5000_0000 | live());
    wrs(32'h5000_0000);
    cfg <= 10'h100;
    evt(20'h400, 32'h8000_0000, 20'h0);
    tick(1);
    ah <= 1'b1;
    rd(32'h0);
    // Clock enable low: a bus reset pulse while frozen is lost, the mismatch flag stays
    tick(1);
    en <= 1'b0;
    pulse(20'h1);
    tick(1);
    en <= 1'b1;
    rd(32'h2 | live());
    tick(2);
    report_and_stop();
  end
endmodule // ois_core_bench
`default_nettype wire
